// >>> verilog/fault_log_recorder.sv
// fault record capture, lock and block read stream
//
// How it works
// - save command captures and commits the record like a real fault
// - save command pulses vendor status fault when logging is enabled
// - save ignored above 130 C until die drops below 125 C
// - 48-bit up-time counter ticks every 200 us, copied into header
// - save is a send-byte with no data bytes after the code
// - read of a captured record reports length 147 and sends 147 bytes
// - read with no captured record reports length zero
// - byte 0 carries the fault cause code
// - bytes 1 to 6 carry up-time, least significant byte first
// - bytes 7 to 10 carry vout peaks page 0 then 1, high first
// - bytes 11 to 14 carry iout peaks page 0 then 1, high first
// - bytes 15 and 16 carry vin peak, high byte first
// - bytes 17 to 22 carry ext0, ext1, internal temperatures
// - bytes 23 to 26 carry temperature peaks page 0 then 1
// - mantissa-only fields hold the bare 16-bit mantissa
// - fault waits for adc step 25 before commit of header and pages
// - newest page is one full adc pass, from byte 27 onward
// - committed record is locked until an erase command or a reset
// - after reset readback, pages five and six repeat page four
// - erase command clears the lock so a new capture can happen
`timescale 1ns/100ps
module fault_log_recorder
	import fault_log_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	// clock and reset
	input  wire logic               CLOCK_I,
	input  wire logic               ARST_N_I,

	// command port, one code per accepted beat
	input  wire logic               CMD_VALID_I,
	input  wire logic [7:0]         CMD_CODE_I,
	input  wire logic [7:0]         CMD_DATA_LEN_I,
	output logic                    CMD_READY_O,

	// block read stream
	output logic                    RD_VALID_O,
	output rd_beat_t                RD_BEAT_O,
	input  wire logic               RD_READY_I,

	// fault events
	input  wire logic               FAULT_I,
	input  wire logic [7:0]         FAULT_CAUSE_I,

	// telemetry from the measurement chain
	input  live_header_t            LIVE_HEADER_I,
	input  event_page_t             EVENT_PAGE_I,
	input  wire logic               ADC_STEP_DONE_I,
	input  wire logic [4:0]         ADC_STEP_I,

	// configuration and environment
	input  wire logic               LOG_ENABLE_CFG_I,
	input  wire logic signed [15:0] DIE_TEMP_I,
	input  wire logic               NVM_READBACK_I,

	// status
	output logic                    VENDOR_STATUS_FAULT_O,
	output logic                    COMMIT_O,
	output logic                    LOG_PRESENT_O,
	output logic                    STORE_PENDING_O,
	output logic                    SAVE_BLOCKED_O
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [UPTIME_W-1:0] uptime_ticks;
	header_t             header;
	event_page_t         pages [PAGE_COUNT];
	logic                locked;
	logic                pending;
	logic [7:0]          pending_cause;
	logic                hot;
	logic                vendor_pulse;
	logic                commit_pulse;

	read_state_t         state;
	read_state_t         next_state;
	logic [7:0]          pos;
	logic [4:0]          off;
	logic [2:0]          pg;
	logic                full_record;

	// ------------------------------------------------------------
	// up-time counter, restarts at zero on every reset
	// ------------------------------------------------------------
	uptime_counter #(
		.TICK_CYCLES_P (TICK_CYCLES_P)
	) u_uptime (
		.clock_i  (CLOCK_I),
		.arst_n_i (ARST_N_I),
		.uptime_o (uptime_ticks)
	);

	// byte swap so that the low byte lands first in the record
	function automatic logic [UPTIME_W-1:0] swap_bytes48(
		input logic [UPTIME_W-1:0] v
	);
		logic [UPTIME_W-1:0] r;
		r = '0;
		for (int i = 0; i < UPTIME_W / 8; i++) begin
			r[UPTIME_W-8-8*i +: 8] = v[8*i +: 8];
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire cmd_fire   = CMD_VALID_I && CMD_READY_O;
	// a code followed by data bytes is not a send-byte; drop it
	wire cmd_bare   = (CMD_DATA_LEN_I == 8'h00);
	wire save_cmd   = cmd_fire && cmd_bare
		&& (CMD_CODE_I == FAULT_RECORD_SAVE_CMD);
	wire read_cmd   = cmd_fire && cmd_bare
		&& (CMD_CODE_I == FAULT_RECORD_READ_CMD);
	wire erase_cmd  = cmd_fire && cmd_bare
		&& (CMD_CODE_I == FAULT_RECORD_ERASE_CMD);

	// commands are taken only between read streams
	assign CMD_READY_O = (state == RD_IDLE);

	// ------------------------------------------------------------
	// save gating by die temperature
	// ------------------------------------------------------------
	// hysteresis keeps the gate from chattering near the limit
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			hot <= 1'b0;
		end else if (hot) begin
			hot <= !(DIE_TEMP_I < TEMP_SAVE_ON);
		end else begin
			hot <= (DIE_TEMP_I > TEMP_SAVE_OFF);
		end
	end

	// a save behaves like a fault from here on, apart from its SAVE_CAUSE code and the vendor pulse
	wire save_ok    = save_cmd && !hot;
	wire trigger    = FAULT_I || save_ok;
	// a locked record or a capture in flight swallows new triggers
	wire fault_take = trigger && !locked && !pending;
	// real fault cause wins when both arrive together
	wire [7:0] take_cause = FAULT_I ? FAULT_CAUSE_I : SAVE_CAUSE;

	// ------------------------------------------------------------
	// adc pass boundary and commit
	// ------------------------------------------------------------
	wire pass_end   = ADC_STEP_DONE_I && (ADC_STEP_I == ADC_LAST_STEP);
	// commit only once the running pass has reached its last step
	wire commit     = pending && pass_end && !locked;

	// pending capture holds the cause until the pass completes
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			pending       <= 1'b0;
			pending_cause <= 8'h00;
		end else if (fault_take) begin
			pending       <= 1'b1;
			pending_cause <= take_cause;
		end else if (commit) begin
			pending       <= 1'b0;
		end
	end

	// lock: commit sets, erase clears, commit wins a tie
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			locked <= 1'b0;
		end else if (commit) begin
			locked <= 1'b1;
		end else if (erase_cmd) begin
			locked <= 1'b0;
		end
	end

	// header is frozen at the commit edge
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			header <= '0;
		end else if (commit) begin
			header.cause     <= pending_cause;
			header.uptime_le <= swap_bytes48(uptime_ticks);
			// peaks and temperatures keep their record order
			header.live      <= LIVE_HEADER_I;
		end
	end

	// ------------------------------------------------------------
	// event page history, newest at index 0
	// ------------------------------------------------------------
	// pages stop moving once locked, so the stored copy is stable
	wire page_shift = pass_end && !locked;

	// newest slot takes the pass that just ended
	always_ff @(posedge CLOCK_I) begin
		if (page_shift) begin
			pages[0] <= EVENT_PAGE_I;
		end
	end

	// older slots each take their younger neighbour
	generate
		for (genvar g = 1; g < PAGE_COUNT; g++) begin : g_hist
			always_ff @(posedge CLOCK_I) begin
				if (page_shift) begin
					pages[g] <= pages[g-1];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// status pulses
	// ------------------------------------------------------------
	// vendor fault flags the forced save only when logging is on
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			vendor_pulse <= 1'b0;
			commit_pulse <= 1'b0;
		end else begin
			vendor_pulse <= save_ok && LOG_ENABLE_CFG_I;
			commit_pulse <= commit;
		end
	end

	assign VENDOR_STATUS_FAULT_O = vendor_pulse;
	assign COMMIT_O              = commit_pulse;
	assign LOG_PRESENT_O         = locked;
	assign STORE_PENDING_O       = pending;
	assign SAVE_BLOCKED_O        = hot;

	// ------------------------------------------------------------
	// read stream byte selection
	// ------------------------------------------------------------
	wire header_bytes_t hdr_b    = header_bytes_t'(header);
	// eeprom copy lost the two oldest pages; fold them onto page 4
	wire [2:0]          pg_eff   = (NVM_READBACK_I && (pg > NVM_LAST_PAGE))
		? NVM_LAST_PAGE : pg;
	wire page_bytes_t   pg_b     = page_bytes_t'(pages[pg_eff]);
	wire                in_hdr   = (pos <= HEADER_BYTES);
	// header byte k sits at packed index 26 - k, k = pos - 1
	wire [4:0]          hdr_idx  = 5'(HEADER_BYTES - pos);
	wire [4:0]          page_idx = PAGE_LAST_BYTE - off;
	wire [7:0]          len_byte = full_record ? RECORD_LEN : EMPTY_LEN;

	// vout fields are passed through as bare mantissas
	wire [7:0] rec_byte = in_hdr ? hdr_b[hdr_idx]
		: pg_b[page_idx];

	// length first, then record bytes in ascending order
	wire [7:0] beat_data = (pos == 8'h00) ? len_byte
		: rec_byte;
	wire       beat_last = ((pos == 8'h00) && !full_record)
		|| (pos == RECORD_LEN);

	rd_beat_t  beat;
	logic      buf_ready;

	assign beat.data = beat_data;
	assign beat.last = beat_last;

	wire push = (state == RD_SEND) && buf_ready;

	// ------------------------------------------------------------
	// read state machine
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			RD_IDLE: begin
				if (read_cmd) begin
					next_state = RD_SEND;
				end
			end
			RD_SEND: begin
				if (push && beat_last) begin
					next_state = RD_IDLE;
				end
			end
			default: begin
				next_state = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state <= RD_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// presence is sampled at the start so a late commit cannot
	// change the length of a stream already under way
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			full_record <= 1'b0;
		end else if (read_cmd) begin
			full_record <= locked;
		end
	end

	// byte position and page walk counters
	always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			pos <= 8'h00;
			off <= 5'h00;
			pg  <= 3'h0;
		end else if (read_cmd) begin
			pos <= 8'h00;
			off <= 5'h00;
			pg  <= 3'h0;
		end else if (push) begin
			pos <= pos + 8'h01;
			if (!in_hdr) begin
				off <= (off == PAGE_LAST_BYTE) ? 5'h00 : off + 5'h01;
				pg  <= (off == PAGE_LAST_BYTE) ? pg + 3'h1 : pg;
			end
		end
	end

	// ------------------------------------------------------------
	// output buffer, lets the reader stall without loss
	// ------------------------------------------------------------
	beat_buffer u_buf (
		.clock_i     (CLOCK_I),
		.arst_n_i    (ARST_N_I),
		.in_valid_i  (state == RD_SEND),
		.in_beat_i   (beat),
		.in_ready_o  (buf_ready),
		.out_valid_o (RD_VALID_O),
		.out_beat_o  (RD_BEAT_O),
		.out_ready_i (RD_READY_I)
	);

endmodule

// >>> verilog/fault_log_pkg.sv
// constants and carrier types shared by the fault record recorder
package fault_log_pkg;

	// command codes seen on the command port
	localparam logic [7:0] FAULT_RECORD_SAVE_CMD  = 8'hEA;
	localparam logic [7:0] FAULT_RECORD_READ_CMD  = 8'hEE;
	localparam logic [7:0] FAULT_RECORD_ERASE_CMD = 8'hEC;

	// cause code stored when a save command forces the capture
	localparam logic [7:0] SAVE_CAUSE = 8'hFF;

	// record geometry
	localparam int         HEADER_N       = 27;
	localparam int         PAGE_N         = 20;
	localparam int         PAGE_COUNT     = 6;
	localparam logic [7:0] RECORD_LEN     = 8'h93;
	localparam logic [7:0] EMPTY_LEN      = 8'h00;
	localparam logic [7:0] HEADER_BYTES   = 8'h1B;
	localparam logic [4:0] PAGE_LAST_BYTE = 5'h13;
	localparam logic [2:0] NVM_LAST_PAGE  = 3'h3;

	// last step of one adc multiplexer pass
	localparam logic [4:0] ADC_LAST_STEP = 5'h19;

	// die temperature limits for the save command, whole degrees
	localparam logic signed [15:0] TEMP_SAVE_OFF = 16'sh0082;
	localparam logic signed [15:0] TEMP_SAVE_ON  = 16'sh007D;

	// up-time tick
	localparam int TICK_TIME_US = 200;
	localparam int CLOCK_MHZ    = 250;
	localparam int TICK_CYCLES  = TICK_TIME_US * CLOCK_MHZ;
	localparam int UPTIME_W     = 48;

	// live values copied into the header, record order
	typedef struct packed {
		logic [15:0] vout_pk0;
		logic [15:0] vout_pk1;
		logic [15:0] iout_pk0;
		logic [15:0] iout_pk1;
		logic [15:0] vin_pk;
		logic [15:0] temp_ext0;
		logic [15:0] temp_ext1;
		logic [15:0] temp_int;
		logic [15:0] temp_pk0;
		logic [15:0] temp_pk1;
	} live_header_t;

	// header as stored, first field is byte 0
	typedef struct packed {
		logic [7:0]          cause;
		logic [UPTIME_W-1:0] uptime_le;
		live_header_t        live;
	} header_t;

	// one adc pass worth of telemetry, record order
	typedef struct packed {
		logic [15:0] vout0;
		logic [15:0] vout1;
		logic [15:0] iout0;
		logic [15:0] iout1;
		logic [15:0] vin;
		logic [15:0] iin;
		logic [7:0]  stat_vout0;
		logic [7:0]  stat_vout1;
		logic [15:0] stat_word0;
		logic [15:0] stat_word1;
		logic [7:0]  stat_vendor0;
		logic [7:0]  stat_vendor1;
	} event_page_t;

	typedef logic [HEADER_N-1:0][7:0] header_bytes_t;
	typedef logic [PAGE_N-1:0][7:0]   page_bytes_t;

	// one beat of the read stream
	typedef struct packed {
		logic       last;
		logic [7:0] data;
	} rd_beat_t;

	typedef enum logic {RD_IDLE, RD_SEND} read_state_t;

endpackage

// >>> verilog/uptime_counter.sv
// free running up-time counter in fixed tick increments
`timescale 1ns/100ps
module uptime_counter
	import fault_log_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	// clock and reset
	input  wire logic                clock_i,
	input  wire logic                arst_n_i,
	// count
	output logic [UPTIME_W-1:0]      uptime_o
);

	logic [31:0] div;
	wire         tick = (div == 32'(TICK_CYCLES_P - 1));

	// prescaler, then the wide count; reset restarts both at zero
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div      <= 32'h0000_0000;
			uptime_o <= '0;
		end else begin
			div      <= tick ? 32'h0000_0000 : div + 32'h0000_0001;
			uptime_o <= uptime_o + UPTIME_W'(tick);
		end
	end

endmodule

// >>> verilog/beat_buffer.sv
// two-entry buffer for read stream beats
`timescale 1ns/100ps
module beat_buffer
	import fault_log_pkg::*;
(
	// clock and reset
	input  wire logic     clock_i,
	input  wire logic     arst_n_i,
	// fill side
	input  wire logic     in_valid_i,
	input  rd_beat_t      in_beat_i,
	output logic          in_ready_o,
	// drain side
	output logic          out_valid_o,
	output rd_beat_t      out_beat_o,
	input  wire logic     out_ready_i
);

	rd_beat_t   mem [2];
	logic       wr_ptr;
	logic       rd_ptr;
	logic [1:0] count;

	wire push = in_valid_i && in_ready_o;
	wire pop  = out_valid_o && out_ready_i;

	// full and empty come straight from the count
	assign in_ready_o  = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign out_beat_o  = mem[rd_ptr];

	// storage is written only, never reset
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= in_beat_i;
		end
	end

	// pointers and count
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			wr_ptr <= wr_ptr ^ push;
			rd_ptr <= rd_ptr ^ pop;
			count  <= count + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule

// >>> tb/fault_log_recorder_sva.sv
// checker for the fault record recorder ports
`timescale 1ns/100ps
module fault_log_recorder_sva
	import fault_log_pkg::*;
(
	// clock and reset
	input  wire logic               CLOCK_I,
	input  wire logic               ARST_N_I,
	// command port
	input  wire logic               CMD_VALID_I,
	input  wire logic [7:0]         CMD_CODE_I,
	input  wire logic [7:0]         CMD_DATA_LEN_I,
	input  wire logic               CMD_READY_O,
	// read stream
	input  wire logic               RD_VALID_O,
	input  rd_beat_t                RD_BEAT_O,
	input  wire logic               RD_READY_I,
	// events and environment
	input  wire logic               FAULT_I,
	input  wire logic               ADC_STEP_DONE_I,
	input  wire logic [4:0]         ADC_STEP_I,
	input  wire logic               LOG_ENABLE_CFG_I,
	input  wire logic signed [15:0] DIE_TEMP_I,
	// status
	input  wire logic               VENDOR_STATUS_FAULT_O,
	input  wire logic               COMMIT_O,
	input  wire logic               LOG_PRESENT_O,
	input  wire logic               STORE_PENDING_O,
	input  wire logic               SAVE_BLOCKED_O
);
	logic take;
	logic save_tk;
	logic bad_save;
	logic read_tk;
	logic erase_tk;
	logic pass_end;

	// taken command beats; save, read and erase count only at zero data length
	assign take     = CMD_VALID_I && CMD_READY_O;
	assign save_tk  = take && CMD_DATA_LEN_I == 8'h00
		&& CMD_CODE_I == FAULT_RECORD_SAVE_CMD;
	assign bad_save = take && CMD_DATA_LEN_I != 8'h00
		&& CMD_CODE_I == FAULT_RECORD_SAVE_CMD;
	assign read_tk  = take && CMD_DATA_LEN_I == 8'h00
		&& CMD_CODE_I == FAULT_RECORD_READ_CMD;
	assign erase_tk = take && CMD_DATA_LEN_I == 8'h00
		&& CMD_CODE_I == FAULT_RECORD_ERASE_CMD;
	assign pass_end = ADC_STEP_DONE_I && ADC_STEP_I == ADC_LAST_STEP;

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!ARST_N_I);

	a_save_pends: assert property (save_tk && !SAVE_BLOCKED_O
		&& !FAULT_I && !LOG_PRESENT_O && !STORE_PENDING_O && !pass_end
		|=> STORE_PENDING_O) else $error("save did not start a capture");
	a_vendor_pulse: assert property (save_tk && LOG_ENABLE_CFG_I
		&& !SAVE_BLOCKED_O && !STORE_PENDING_O |=> VENDOR_STATUS_FAULT_O)
		else $error("vendor status pulse missing");
	a_vendor_cause: assert property (VENDOR_STATUS_FAULT_O |->
		$past(save_tk && LOG_ENABLE_CFG_I))
		else $error("vendor status pulse without save");
	a_hot_blocks: assert property (DIE_TEMP_I > TEMP_SAVE_OFF
		|=> SAVE_BLOCKED_O) else $error("hot die not blocking save");
	a_cool_frees: assert property (DIE_TEMP_I < TEMP_SAVE_ON
		|=> !SAVE_BLOCKED_O) else $error("cool die still blocking");
	a_band_holds: assert property (DIE_TEMP_I >= TEMP_SAVE_ON
		&& DIE_TEMP_I <= TEMP_SAVE_OFF |=> $stable(SAVE_BLOCKED_O))
		else $error("block flag moved inside band");
	a_blocked_save: assert property (save_tk && SAVE_BLOCKED_O
		&& !FAULT_I && !STORE_PENDING_O |=> !STORE_PENDING_O
		&& !VENDOR_STATUS_FAULT_O) else $error("blocked save acted");
	a_len_refused: assert property (bad_save && !FAULT_I
		&& !STORE_PENDING_O |=> !STORE_PENDING_O)
		else $error("save with data bytes acted");
	a_first_len: assert property (read_tk && LOG_PRESENT_O |-> ##2
		RD_VALID_O && RD_BEAT_O.data == RECORD_LEN)
		else $error("full length beat wrong");
	a_empty_len: assert property (read_tk && !LOG_PRESENT_O |-> ##2
		RD_VALID_O && RD_BEAT_O == {1'b1, EMPTY_LEN})
		else $error("empty length beat wrong");
	a_commit_step: assert property (COMMIT_O |->
		$past(pass_end && STORE_PENDING_O))
		else $error("commit before end of pass");
	a_commit_locks: assert property (COMMIT_O |-> LOG_PRESENT_O
		&& !STORE_PENDING_O) else $error("commit without lock");
	a_lock_holds: assert property (LOG_PRESENT_O && !erase_tk
		|=> LOG_PRESENT_O) else $error("lock dropped without erase");
	a_erase_clears: assert property (erase_tk && !FAULT_I
		&& !(STORE_PENDING_O && pass_end) |=> !LOG_PRESENT_O)
		else $error("erase left the lock");
	a_beat_holds: assert property (RD_VALID_O && !RD_READY_I
		|=> RD_VALID_O && $stable(RD_BEAT_O))
		else $error("stalled beat changed");
	// an empty read ends after its single length beat is pushed
	a_read_busy: assert property (read_tk && LOG_PRESENT_O
		|=> !CMD_READY_O[*8]) else $error("command taken during stream");
	a_empty_busy: assert property (read_tk && !LOG_PRESENT_O
		|=> !CMD_READY_O ##1 CMD_READY_O)
		else $error("empty read held the command port");
endmodule

// >>> tb/pmbus_host_model.sv
// bus host model: command beats and block read collection
`timescale 1ns/100ps
module pmbus_host_model
	import fault_log_pkg::*;
(
	// clock
	input  wire logic  clock_i,
	// command side
	output logic       cmd_valid_o,
	output logic [7:0] cmd_code_o,
	output logic [7:0] cmd_len_o,
	input  wire logic  cmd_ready_i,
	// read side
	input  wire logic  rd_valid_i,
	input  rd_beat_t   rd_beat_i,
	output logic       rd_ready_o
);
	logic       slow;
	logic [7:0] got[$];

	// idle bus at time zero
	initial begin
		slow = 1'b0;
		cmd_valid_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_len_o = 8'h00;
		rd_ready_o = 1'b0;
	end

	// one send-byte, held until taken; idle shows inverted code
	task automatic send(input logic [7:0] code, input logic [7:0] len);
		cmd_code_o = code;
		cmd_len_o = len;
		cmd_valid_o = 1'b1;
		@(posedge clock_i);
		while (cmd_ready_i !== 1'b1)
			@(posedge clock_i);
		#1;
		cmd_valid_o = 1'b0;
		cmd_code_o = ~code;
		cmd_len_o = ~len;
	endtask

	// block read; random stalls when slow, to fill the beat buffer
	task automatic read_block();
		logic done;
		done = 1'b0;
		got.delete();
		send(FAULT_RECORD_READ_CMD, 8'h00);
		while (!done) begin
			rd_ready_o = slow ? 1'($urandom_range(1)) : 1'b1;
			@(posedge clock_i);
			if (rd_valid_i === 1'b1 && rd_ready_o) begin
				got.push_back(rd_beat_i.data);
				done = (rd_beat_i.last === 1'b1);
			end
			#1;
		end
		rd_ready_o = 1'b0;
	endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the fault record recorder
`timescale 1ns/100ps
module testbench;
	import fault_log_pkg::*;
	localparam int TICK = 4;

	logic               clk, arst_n, fault, step_done;
	logic               log_en, readback, cmd_valid, cmd_ready;
	logic               rd_valid, rd_ready, vsf, commit;
	logic               present, pending, blocked;
	logic [7:0]         cause, cmd_code, cmd_len, c;
	logic [4:0]         step;
	logic signed [15:0] temp;
	logic [47:0]        up_exp;
	live_header_t       live;
	event_page_t        page;
	event_page_t        hist[$];
	rd_beat_t           beat;
	int                 fails, tests_run, cyc, wd;

	fault_log_recorder #(.TICK_CYCLES_P(TICK)) DUT (
		.CLOCK_I(clk), .ARST_N_I(arst_n), .CMD_VALID_I(cmd_valid),
		.CMD_CODE_I(cmd_code), .CMD_DATA_LEN_I(cmd_len),
		.CMD_READY_O(cmd_ready), .RD_VALID_O(rd_valid),
		.RD_BEAT_O(beat), .RD_READY_I(rd_ready), .FAULT_I(fault),
		.FAULT_CAUSE_I(cause), .LIVE_HEADER_I(live),
		.EVENT_PAGE_I(page), .ADC_STEP_DONE_I(step_done),
		.ADC_STEP_I(step), .LOG_ENABLE_CFG_I(log_en),
		.DIE_TEMP_I(temp), .NVM_READBACK_I(readback),
		.VENDOR_STATUS_FAULT_O(vsf), .COMMIT_O(commit),
		.LOG_PRESENT_O(present), .STORE_PENDING_O(pending),
		.SAVE_BLOCKED_O(blocked));

	pmbus_host_model host (
		.clock_i(clk), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
		.cmd_len_o(cmd_len), .cmd_ready_i(cmd_ready),
		.rd_valid_i(rd_valid), .rd_beat_i(beat), .rd_ready_o(rd_ready));

	// clock and cycle counts; cyc restarts with reset like the up-time
	initial clk = 1'b0;
	always #2 clk = ~clk;
	always @(posedge clk or negedge arst_n)
		if (!arst_n) cyc <= 0;
		else cyc <= cyc + 1;

	// hang guard, far above the roughly twelve hundred cycles the run needs
	always @(posedge clk) begin
		wd++;
		if (wd == 20000) begin
			fails++;
			conclude();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic do_reset(input int n);
		arst_n = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		arst_n = 1'b1;
	endtask

	task automatic pulse_fault(input logic [7:0] code);
		fault = 1'b1;
		cause = code;
		@(posedge clk);
		#1;
		fault = 1'b0;
		cause = ~code;
	endtask

	// one adc pass of steps 0 to 25 with a fresh random page
	task automatic adc_pass();
		page = {$urandom, $urandom, $urandom, $urandom, $urandom};
		step_done = 1'b1;
		for (int s = 0; s < 26; s++) begin
			step = 5'(s);
			@(posedge clk);
			#1;
		end
		step_done = 1'b0;
		hist.push_front(page);
	endtask

	// byte j of a 160-bit field group, high byte first
	function automatic logic [7:0] hb(input logic [159:0] v, input int j);
		return v[159-8*j -: 8];
	endfunction

	// compare the collected block with the model record
	task automatic check_record(input logic [7:0] cz, input logic nvm);
		logic [47:0] up;
		event_page_t pg;
		check(64'(host.got.size()), 64'd148);
		check(host.got[0], RECORD_LEN);
		check(host.got[1], cz);
		for (int k = 0; k < 6; k++)
			up[8*k +: 8] = host.got[2+k];
		// header time is frozen one edge before up_exp is taken
		check(64'(up + 1 >= up_exp), 64'h1);
		check(64'(up <= up_exp + 1), 64'h1);
		for (int j = 0; j < 4; j++)
			check(host.got[8+j], hb(live, j));
		for (int j = 4; j < 10; j++)
			check(host.got[8+j], hb(live, j));
		for (int j = 10; j < 20; j++)
			check(host.got[8+j], hb(live, j));
		for (int s = 0; s < 6; s++) begin
			pg = hist[(nvm && s > 3) ? 3 : s];
			for (int j = 0; j < 20; j++)
				check(host.got[28+20*s+j], hb(pg, j));
		end
	endtask

	initial begin
		{fault, step_done, readback, cause, step} = '0;
		{wd, fails, tests_run} = '0;
		log_en = 1'b1;
		temp = 16'sh0019;
		live = '0;
		page = '0;
		void'($urandom(32'hf616_acf0));
		do_reset(16);
		host.read_block();
		check(64'(host.got.size()), 64'h1);
		check(host.got[0], EMPTY_LEN);
		host.send(FAULT_RECORD_SAVE_CMD, 8'(1 + $urandom_range(254)));
		check(pending, 1'b0);
		// hot die, then the hysteresis band, then cool
		temp = 16'sh0083;
		@(posedge clk);
		#1;
		host.send(FAULT_RECORD_SAVE_CMD, 8'h00);
		check({blocked, pending, vsf}, 3'b100);
		temp = 16'sh007F;
		@(posedge clk);
		#1;
		check(blocked, 1'b1);
		repeat (24) begin
			temp = 16'sh007C + 16'($urandom_range(8));
			@(posedge clk);
			#1;
		end
		temp = 16'sh007C;
		@(posedge clk);
		#1;
		temp = 16'sh0082;
		@(posedge clk);
		#1;
		check(blocked, 1'b0);
		// forced save lands at the end of the sixth pass
		live = {$urandom, $urandom, $urandom, $urandom, $urandom};
		repeat (5) adc_pass();
		host.send(FAULT_RECORD_SAVE_CMD, 8'h00);
		check({vsf, pending}, 2'b11);
		adc_pass();
		up_exp = 48'(cyc / TICK);
		check({commit, present}, 2'b11);
		host.slow = 1'b1;
		host.read_block();
		check_record(SAVE_CAUSE, 1'b0);
		readback = 1'b1;
		host.read_block();
		check_record(SAVE_CAUSE, 1'b1);
		readback = 1'b0;
		// locked record ignores save and fault
		log_en = 1'b0;
		host.send(FAULT_RECORD_SAVE_CMD, 8'h00);
		check(vsf, 1'b0);
		pulse_fault(8'h11);
		check(pending, 1'b0);
		adc_pass();
		// pages stand still while locked, so this pass is no history
		void'(hist.pop_front());
		check({commit, present}, 2'b01);
		host.send(FAULT_RECORD_ERASE_CMD, 8'h00);
		check(present, 1'b0);
		pulse_fault(8'h22);
		adc_pass();
		check(present, 1'b1);
		// mid-run reset, then a real fault capture
		do_reset(3);
		c = 8'($urandom_range(254));
		pulse_fault(c);
		adc_pass();
		up_exp = 48'(cyc / TICK);
		host.read_block();
		check_record(c, 1'b0);
		conclude();
	end
endmodule

bind fault_log_recorder fault_log_recorder_sva chk (
	.CLOCK_I, .ARST_N_I, .CMD_VALID_I, .CMD_CODE_I, .CMD_DATA_LEN_I,
	.CMD_READY_O, .RD_VALID_O, .RD_BEAT_O, .RD_READY_I, .FAULT_I,
	.ADC_STEP_DONE_I, .ADC_STEP_I, .LOG_ENABLE_CFG_I, .DIE_TEMP_I,
	.VENDOR_STATUS_FAULT_O, .COMMIT_O, .LOG_PRESENT_O,
	.STORE_PENDING_O, .SAVE_BLOCKED_O);
